//--- logic/cap_slice_pkg.sv
// Purpose: constants and carriers for the switch port capability slice
// Assumes: config offsets are byte addresses of aligned dwords
// Notes: field positions are bit indices within the 32-bit dword
`default_nettype none
package cap_slice_pkg;
   // register offsets
   localparam logic [7:0] OFF_MSI_UPPER = 8'h54;
   localparam logic [7:0] OFF_MSI_DATA = 8'h58;
   localparam logic [7:0] OFF_PD_CTRL = 8'h5C;
   localparam logic [7:0] OFF_PD_WORD = 8'h60;
   localparam logic [7:0] OFF_VENDOR = 8'h64;
   localparam logic [7:0] OFF_TEST0 = 8'h68;
   localparam logic [7:0] OFF_TEST1 = 8'h6C;
   localparam logic [7:0] OFF_TIMERS = 8'h70;
   // capability headers
   localparam logic [7:0] PD_CAP_ID = 8'h03;
   localparam logic [7:0] PD_NEXT = 8'h64;
   localparam logic [7:0] VND_CAP_ID = 8'h09;
   localparam logic [7:0] VND_NEXT = 8'hB0;
   localparam logic [15:0] VND_LENGTH = 16'h0034;
   // reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] RST_TEST0 = 32'h0400_1060;
   localparam logic [31:0] RST_TEST1 = 32'h0400_0800;
   localparam logic [5:0] RST_PD_ADDR = 6'h00;
   localparam logic RST_PD_FLAG = 1'b0;
   // field layout
   localparam int PD_ADDR_W = 6;
   localparam int PD_ADDR_LSB = 18;
   localparam int PD_FLAG_BIT = 31;
   localparam int MSI_DATA_W = 16;
   localparam int REPLAY_W = 12;
   localparam int REPLAY_EN_BIT = 12;
   localparam int PM_DIS_BIT = 13;
   localparam int MSI_DIS_BIT = 14;
   localparam int ACK_LSB = 16;
   localparam int ACK_W = 14;
   localparam int ACK_EN_BIT = 30;
   localparam int VGA_BIT = 31;
   localparam int MSI_LO_LSB = 2;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } cfg_req_t;

   typedef struct packed {
      logic [REPLAY_W-1:0] replay_val;
      logic replay_en;
      logic pm_cap_dis;
      logic msi_cap_dis;
      logic [ACK_W-1:0] ack_val;
      logic ack_en;
      logic vga_en;
   } timer_cfg_t;

   localparam timer_cfg_t TIMER_CFG_RST = '{
      replay_val: 12'h000, replay_en: 1'b0, pm_cap_dis: 1'b0,
      msi_cap_dis: 1'b0, ack_val: 14'h0000, ack_en: 1'b0, vga_en: 1'b1};

   typedef enum {PD_IDLE, PD_BUSY} pd_state_t;
endpackage
`default_nettype wire

//--- logic/switch_port_capability_regs.sv
// Purpose: config-space slice: msi upper/data, product data over eeprom,
//    vendor header, test words, link timer overrides
// Assumes: eeprom controller and default loader share sys_clk
// Notes: absent registers read zero and ignore writes
// Function
// - 32-bit msi upper address, downstream, resets zero
// - msi target uses lower address bits 31:2
// - product data header id 03h, next 64h
// - six-bit table address in bits 23:18
// - flag 0 reads eeprom, sets 1 after
// - flag 1 writes eeprom, clears 0 after
// - data read returns last fetched dword
// - data write supplies dword stored, resets zero
// - vendor header id 09h, next B0h
// - vendor length 0034h in bits 31:16
// - 12-bit user replay value, resets zero
// - bit 12 selects user replay limit
// - 14-bit user ack latency, resets zero
// - bit 30 selects user ack latency
// - override defaults reloadable by loader port
// - read-only vga decode enable, resets one
// - read-only pm and msi disable bits
// - product data upstream only, msi downstream
// - 16-bit msi message data, upper reserved
`timescale 1ns/1ps
`default_nettype none
module switch_port_capability_regs #(
   parameter int UPSTREAM_PORT = 1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // configuration access
   input wire cap_slice_pkg::cfg_req_t cfg_req,
   output logic [31:0] cfg_rdata,
   output logic cfg_rd_ack,
   // msi message generation
   input wire logic [31:0] msi_lower_addr,
   input wire logic msi_64bit_capable,
   output logic [63:0] msi_target_addr,
   output logic [cap_slice_pkg::MSI_DATA_W-1:0] msi_message_data,
   // eeprom controller
   output logic ee_req,
   output logic ee_write,
   output logic [cap_slice_pkg::PD_ADDR_W-1:0] ee_addr,
   output logic [31:0] ee_wdata,
   input wire logic ee_ack,
   input wire logic [31:0] ee_rdata,
   // default reload from smbus or eeprom auto-load
   input wire logic dflt_load,
   input wire cap_slice_pkg::timer_cfg_t dflt_value,
   // data link layer and decode controls
   output cap_slice_pkg::timer_cfg_t timer_cfg,
   output logic pd_busy
);

   // refused at elaboration, before any logic is built
   if (UPSTREAM_PORT != 0 && UPSTREAM_PORT != 1)
   begin
      $error("UPSTREAM_PORT must be 0 or 1");
   end

   localparam bit IS_UP = (UPSTREAM_PORT == 1);

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic wr_hit(input cap_slice_pkg::cfg_req_t q,
                                   input logic [7:0] off);
      return q.wr && (q.addr == off);
   endfunction

   function automatic logic [31:0] timer_word(
      input cap_slice_pkg::timer_cfg_t t);
      logic [31:0] w;
      w = cap_slice_pkg::RST_ZERO;
      w[cap_slice_pkg::REPLAY_W-1:0] = t.replay_val;
      w[cap_slice_pkg::REPLAY_EN_BIT] = t.replay_en;
      w[cap_slice_pkg::PM_DIS_BIT] = t.pm_cap_dis;
      w[cap_slice_pkg::MSI_DIS_BIT] = t.msi_cap_dis;
      w[cap_slice_pkg::ACK_LSB +: cap_slice_pkg::ACK_W] = t.ack_val;
      w[cap_slice_pkg::ACK_EN_BIT] = t.ack_en;
      w[cap_slice_pkg::VGA_BIT] = t.vga_en;
      return w;
   endfunction

   logic [31:0] msi_upper_reg;
   logic [cap_slice_pkg::MSI_DATA_W-1:0] msi_data_reg;
   logic [cap_slice_pkg::PD_ADDR_W-1:0] pd_addr_reg;
   logic pd_flag_reg;
   logic [31:0] pd_data_reg;
   logic [31:0] test0_reg;
   logic [31:0] test1_reg;
   cap_slice_pkg::timer_cfg_t timer_reg;
   cap_slice_pkg::pd_state_t pd_state_reg;
   logic [63:0] msi_addr_reg;
   logic [31:0] rdata_reg;
   logic rd_ack_reg;
   logic [31:0] rd_word;
   logic [31:0] timer_wr;
   logic [31:0] msi_data_wr;
   logic pd_idle;
   logic pd_start;

   assign pd_idle = (pd_state_reg == cap_slice_pkg::PD_IDLE);
   // requests arriving mid-cycle are dropped; software polls the flag
   assign pd_start = IS_UP && pd_idle && cfg_req.be[3] &&
                     wr_hit(cfg_req, cap_slice_pkg::OFF_PD_CTRL);
   assign timer_wr = merge(timer_word(timer_reg), cfg_req.wdata, cfg_req.be);
   // reserved upper half is never stored, so it reads back as zero
   assign msi_data_wr = merge({16'h0000, msi_data_reg}, cfg_req.wdata,
                              cfg_req.be);

   // msi registers exist only on downstream ports
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         msi_upper_reg <= cap_slice_pkg::RST_ZERO;
      end
      else if (!IS_UP && wr_hit(cfg_req, cap_slice_pkg::OFF_MSI_UPPER))
      begin
         msi_upper_reg <= merge(msi_upper_reg, cfg_req.wdata,
                                cfg_req.be);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         msi_data_reg <= cap_slice_pkg::RST_ZERO[15:0];
      end
      else if (!IS_UP && wr_hit(cfg_req, cap_slice_pkg::OFF_MSI_DATA))
      begin
         msi_data_reg <=
            msi_data_wr[cap_slice_pkg::MSI_DATA_W-1:0];
      end
   end

   // upper half only counts when 64-bit addressing is advertised
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         msi_addr_reg <= {cap_slice_pkg::RST_ZERO, cap_slice_pkg::RST_ZERO};
      end
      else
      begin
         msi_addr_reg[63:32] <= msi_64bit_capable ? msi_upper_reg
                                : cap_slice_pkg::RST_ZERO;
         msi_addr_reg[31:0] <= {msi_lower_addr[31:cap_slice_pkg::MSI_LO_LSB],
                                2'h0};
      end
   end

   // product data state machine
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pd_state_reg <= cap_slice_pkg::PD_IDLE;
      end
      else
      begin
         unique case (pd_state_reg)
            cap_slice_pkg::PD_IDLE:
            begin
               if (pd_start)
               begin
                  pd_state_reg <= cap_slice_pkg::PD_BUSY;
               end
            end
            cap_slice_pkg::PD_BUSY:
            begin
               if (ee_ack)
               begin
                  pd_state_reg <= cap_slice_pkg::PD_IDLE;
               end
            end
         endcase
      end
   end

   // flag holds the written direction while busy, inverts on completion
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pd_flag_reg <= cap_slice_pkg::RST_PD_FLAG;
      end
      else if (pd_start)
      begin
         pd_flag_reg <= cfg_req.wdata[cap_slice_pkg::PD_FLAG_BIT];
      end
      else if (!pd_idle && ee_ack)
      begin
         pd_flag_reg <= ~pd_flag_reg;
      end
   end

   // address is frozen while a cycle runs so the eeprom sees one location
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pd_addr_reg <= cap_slice_pkg::RST_PD_ADDR;
      end
      else if (IS_UP && pd_idle && cfg_req.be[2] &&
               wr_hit(cfg_req, cap_slice_pkg::OFF_PD_CTRL))
      begin
         pd_addr_reg <= cfg_req.wdata[cap_slice_pkg::PD_ADDR_LSB +:
                                      cap_slice_pkg::PD_ADDR_W];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pd_data_reg <= cap_slice_pkg::RST_ZERO;
      end
      else if (!pd_idle && ee_ack && !pd_flag_reg)
      begin
         pd_data_reg <= ee_rdata;
      end
      else if (IS_UP && pd_idle &&
               wr_hit(cfg_req, cap_slice_pkg::OFF_PD_WORD))
      begin
         pd_data_reg <= merge(pd_data_reg, cfg_req.wdata,
                              cfg_req.be);
      end
   end

   // test-only words, no effect in this slice
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         test0_reg <= cap_slice_pkg::RST_TEST0;
         test1_reg <= cap_slice_pkg::RST_TEST1;
      end
      else
      begin
         if (wr_hit(cfg_req, cap_slice_pkg::OFF_TEST0))
         begin
            test0_reg <= merge(test0_reg, cfg_req.wdata, cfg_req.be);
         end
         if (wr_hit(cfg_req, cap_slice_pkg::OFF_TEST1))
         begin
            test1_reg <= merge(test1_reg, cfg_req.wdata, cfg_req.be);
         end
      end
   end

   // loader beats software so a reload always lands whole
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         timer_reg <= cap_slice_pkg::TIMER_CFG_RST;
      end
      else if (dflt_load)
      begin
         timer_reg <= dflt_value;
      end
      else if (wr_hit(cfg_req, cap_slice_pkg::OFF_TIMERS))
      begin
         timer_reg.replay_val <=
            timer_wr[cap_slice_pkg::REPLAY_W-1:0];
         timer_reg.replay_en <=
            timer_wr[cap_slice_pkg::REPLAY_EN_BIT];
         timer_reg.ack_val <=
            timer_wr[cap_slice_pkg::ACK_LSB +: cap_slice_pkg::ACK_W];
         timer_reg.ack_en <= timer_wr[cap_slice_pkg::ACK_EN_BIT];
      end
   end

   always_comb
   begin
      rd_word = cap_slice_pkg::RST_ZERO;
      unique case (cfg_req.addr)
         cap_slice_pkg::OFF_MSI_UPPER:
            rd_word = IS_UP ? cap_slice_pkg::RST_ZERO : msi_upper_reg;
         cap_slice_pkg::OFF_MSI_DATA:
            rd_word = IS_UP ? cap_slice_pkg::RST_ZERO
                            : {16'h0000, msi_data_reg};
         cap_slice_pkg::OFF_PD_CTRL:
         begin
            if (IS_UP)
            begin
               rd_word[15:0] = {cap_slice_pkg::PD_NEXT,
                                cap_slice_pkg::PD_CAP_ID};
               rd_word[cap_slice_pkg::PD_ADDR_LSB +:
                       cap_slice_pkg::PD_ADDR_W] = pd_addr_reg;
               rd_word[cap_slice_pkg::PD_FLAG_BIT] = pd_flag_reg;
            end
         end
         cap_slice_pkg::OFF_PD_WORD:
            rd_word = IS_UP ? pd_data_reg : cap_slice_pkg::RST_ZERO;
         cap_slice_pkg::OFF_VENDOR:
            rd_word = {cap_slice_pkg::VND_LENGTH, cap_slice_pkg::VND_NEXT,
                       cap_slice_pkg::VND_CAP_ID};
         cap_slice_pkg::OFF_TEST0:
            rd_word = test0_reg;
         cap_slice_pkg::OFF_TEST1:
            rd_word = test1_reg;
         cap_slice_pkg::OFF_TIMERS:
            rd_word = timer_word(timer_reg);
         default:
            rd_word = cap_slice_pkg::RST_ZERO;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         rdata_reg <= cap_slice_pkg::RST_ZERO;
         rd_ack_reg <= 1'b0;
      end
      else
      begin
         rd_ack_reg <= cfg_req.rd;
         if (cfg_req.rd)
         begin
            rdata_reg <= rd_word;
         end
      end
   end

   assign cfg_rdata = rdata_reg;
   assign cfg_rd_ack = rd_ack_reg;
   assign msi_target_addr = msi_addr_reg;
   assign msi_message_data = msi_data_reg;
   assign ee_req = !pd_idle;
   assign ee_write = pd_flag_reg;
   assign ee_addr = pd_addr_reg;
   assign ee_wdata = pd_data_reg;
   assign timer_cfg = timer_reg;
   assign pd_busy = !pd_idle;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_read_start;
      pd_start && !cfg_req.wdata[31];
   endsequence
   sequence s_done(logic dir);
      !pd_idle && ee_ack && (pd_flag_reg == dir);
   endsequence

   property p_msi_upper;
      (!IS_UP && wr_hit(cfg_req, cap_slice_pkg::OFF_MSI_UPPER) &&
       cfg_req.be == 4'hF) |=> msi_upper_reg == $past(cfg_req.wdata);
   endproperty
   a_msi_upper: assert property (p_msi_upper)
      else $error("msi upper address not stored");

   property p_msi_lower;
      ##1 msi_target_addr[31:0] == {$past(msi_lower_addr[31:2]), 2'h0};
   endproperty
   a_msi_lower: assert property (p_msi_lower)
      else $error("msi target address not dword aligned");

   property p_pd_header;
      (IS_UP && cfg_req.rd && cfg_req.addr == cap_slice_pkg::OFF_PD_CTRL)
         |=> cfg_rdata[15:0] == 16'h6403;
   endproperty
   a_pd_header: assert property (p_pd_header)
      else $error("product data header wrong");

   property p_read_cycle;
      s_read_start |=> (pd_busy && !pd_flag_reg && ee_req && !ee_write);
   endproperty
   a_read_cycle: assert property (p_read_cycle)
      else $error("read cycle not started with flag low");

   property p_read_done;
      s_done(1'b0) |=> pd_flag_reg && !pd_busy &&
                       pd_data_reg == $past(ee_rdata);
   endproperty
   a_read_done: assert property (p_read_done)
      else $error("read completion wrong");

   property p_write_done;
      s_done(1'b1) |=> !pd_flag_reg && !pd_busy && $stable(pd_data_reg);
   endproperty
   a_write_done: assert property (p_write_done)
      else $error("write completion wrong");

   property p_vendor;
      (cfg_req.rd && cfg_req.addr == cap_slice_pkg::OFF_VENDOR)
         |=> cfg_rd_ack && cfg_rdata == 32'h0034_B009;
   endproperty
   a_vendor: assert property (p_vendor)
      else $error("vendor header wrong");

   property p_replay_en;
      (!dflt_load && wr_hit(cfg_req, cap_slice_pkg::OFF_TIMERS) &&
       cfg_req.be[1]) |=> timer_cfg.replay_en == $past(cfg_req.wdata[12]);
   endproperty
   a_replay_en: assert property (p_replay_en)
      else $error("replay enable not written");

   property p_reload;
      dflt_load |=> timer_cfg == $past(dflt_value);
   endproperty
   a_reload: assert property (p_reload)
      else $error("default reload lost");

   property p_absent;
      (cfg_req.rd && (IS_UP ? (cfg_req.addr == cap_slice_pkg::OFF_MSI_UPPER)
                            : (cfg_req.addr == cap_slice_pkg::OFF_PD_WORD)))
         |=> cfg_rdata == 32'h0000_0000;
   endproperty
   a_absent: assert property (p_absent)
      else $error("absent register read nonzero");

   // a read paired with a write returns the value before that write
   property p_vga;
      (cfg_req.rd && cfg_req.addr == cap_slice_pkg::OFF_TIMERS)
         |=> cfg_rdata[31] == $past(timer_cfg.vga_en) &&
             cfg_rdata[30:16] ==
                $past({timer_cfg.ack_en, timer_cfg.ack_val});
   endproperty
   a_vga: assert property (p_vga)
      else $error("timer dword read wrong");

endmodule
`default_nettype wire

//--- dv/ee_table_model.sv
// Purpose: behavioural eeprom controller holding the product data table
// Assumes: one request at a time, held steady until acknowledged
// Notes: read data is scrambled outside the ack cycle, so a stale
//    capture never passes for a fresh one
`timescale 1ns/1ps
`default_nettype none
module ee_table_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // request side
   input wire logic ee_req,
   input wire logic ee_write,
   input wire logic [cap_slice_pkg::PD_ADDR_W-1:0] ee_addr,
   input wire logic [31:0] ee_wdata,
   input wire logic [3:0] ack_dly,
   // answer side
   output logic ee_ack,
   output logic [31:0] ee_rdata
);
   logic [31:0] mem [64];
   logic [3:0] wait_cnt;
   logic done;

   initial
   begin
      for (int i = 0; i < 64; i++)
      begin
         mem[i] = 32'hC3005A5A | (32'(i) << 16);
      end
   end

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ee_ack <= 1'b0;
         done <= 1'b0;
         wait_cnt <= 4'h0;
         ee_rdata <= 32'h0;
      end
      else if (ee_ack)
      begin
         ee_ack <= 1'b0;
         done <= 1'b1;
         ee_rdata <= ~ee_rdata;
      end
      else if (!ee_req)
      begin
         done <= 1'b0;
         wait_cnt <= 4'h0;
         ee_rdata <= ~ee_rdata;
      end
      else if (!done)
      begin
         // slow answers on purpose: the flag must hold the whole time
         if (wait_cnt >= ack_dly)
         begin
            ee_ack <= 1'b1;
            if (ee_write)
               mem[ee_addr] <= ee_wdata;
            else
               ee_rdata <= mem[ee_addr];
         end
         else
            wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

//--- dv/test_switch_port_capability_regs.sv
// Purpose: self-checking bench for the capability register slice
// Assumes: one upstream and one downstream copy share the config bus
// Notes: expected reads are queued by the driver, checked on ack
`timescale 1ns/1ps
`default_nettype none
module test_switch_port_capability_regs;
   logic sys_clk, rst_n, msi_64bit_capable, dflt_load;
   cap_slice_pkg::cfg_req_t cfg_req;
   cap_slice_pkg::timer_cfg_t dflt_value, up_tcfg, dn_tcfg, tsh;
   logic [31:0] msi_lower_addr, up_rdata, dn_rdata, ee_wdata, ee_rdata;
   logic up_ack, dn_ack, up_busy, dn_busy, ee_req, ee_write, ee_ack;
   logic [63:0] dn_target;
   logic [15:0] dn_mdata, mdat;
   logic [5:0] ee_addr, pd_addr;
   logic [3:0] ack_dly;
   logic [31:0] upr, t0, t1, pd_data, seed, la;
   logic [31:0] tbl [64];
   logic pd_flag;
   logic [63:0] exp_q [$];
   logic [7:0] wr_offs [6] = '{8'h54, 8'h58, 8'h64, 8'h68, 8'h6C, 8'h70};
   int error_cnt = 0;
   int checks_done = 0;

   switch_port_capability_regs #(.UPSTREAM_PORT(1)) dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .cfg_req(cfg_req),
      .cfg_rdata(up_rdata), .cfg_rd_ack(up_ack),
      .msi_lower_addr(msi_lower_addr), .msi_64bit_capable(msi_64bit_capable),
      .msi_target_addr(), .msi_message_data(), .ee_req(ee_req),
      .ee_write(ee_write), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
      .ee_ack(ee_ack), .ee_rdata(ee_rdata), .dflt_load(dflt_load),
      .dflt_value(dflt_value), .timer_cfg(up_tcfg), .pd_busy(up_busy));
   switch_port_capability_regs #(.UPSTREAM_PORT(0)) dut_dn (
      .sys_clk(sys_clk), .rst_n(rst_n), .cfg_req(cfg_req),
      .cfg_rdata(dn_rdata), .cfg_rd_ack(dn_ack),
      .msi_lower_addr(msi_lower_addr), .msi_64bit_capable(msi_64bit_capable),
      .msi_target_addr(dn_target), .msi_message_data(dn_mdata), .ee_req(),
      .ee_write(), .ee_addr(), .ee_wdata(), .ee_ack(1'b0),
      .ee_rdata(32'h0), .dflt_load(dflt_load), .dflt_value(dflt_value),
      .timer_cfg(dn_tcfg), .pd_busy(dn_busy));
   ee_table_model eeprom (
      .sys_clk(sys_clk), .rst_n(rst_n), .ee_req(ee_req),
      .ee_write(ee_write), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
      .ack_dly(ack_dly), .ee_ack(ee_ack), .ee_rdata(ee_rdata));

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   function automatic logic [31:0] mg(input logic [31:0] o, input logic [31:0] d,
                                      input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return (o & ~m) | (d & m);
   endfunction

   function automatic logic [31:0] tword(input cap_slice_pkg::timer_cfg_t t);
      return {t.vga_en, t.ack_en, t.ack_val, 1'b0, t.msi_cap_dis,
              t.pm_cap_dis, t.replay_en, t.replay_val};
   endfunction

   // upper half is the downstream copy, lower half the upstream copy
   function automatic logic [63:0] exp_rd(input logic [7:0] a);
      case (a)
         8'h54: return {upr, 32'h0};
         8'h58: return {16'h0, mdat, 32'h0};
         8'h5C: return {32'h0, pd_flag, 7'h0, pd_addr, 2'b00, 16'h6403};
         8'h60: return {32'h0, pd_data};
         8'h64: return {2{32'h0034B009}};
         8'h68: return {2{t0}};
         8'h6C: return {2{t1}};
         8'h70: return {2{tword(tsh)}};
         default: return 64'h0;
      endcase
   endfunction

   task automatic op(input logic rd, input logic wr, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d);
      cfg_req = '{rd: rd, wr: wr, addr: a, be: be, wdata: d};
      if (rd)
         exp_q.push_back(exp_rd(a));
      if (wr && a == 8'h54)
         upr = mg(upr, d, be);
      if (wr && a == 8'h58)
         mdat = mg({16'h0, mdat}, d, be) & 16'hFFFF;
      if (wr && a == 8'h68)
         t0 = mg(t0, d, be);
      if (wr && a == 8'h6C)
         t1 = mg(t1, d, be);
      if (wr && a == 8'h70)
         tsh = '{replay_val: d[11:0], replay_en: d[12], ack_val: d[29:16],
                 ack_en: d[30], default: 1'b0, pm_cap_dis: tsh.pm_cap_dis,
                 msi_cap_dis: tsh.msi_cap_dis, vga_en: tsh.vga_en};
      @(negedge sys_clk);
   endtask

   task automatic vpd(input logic dir, input logic [5:0] a, input logic [31:0] d);
      int n;
      ack_dly = 4'($urandom_range(2, 9));
      if (dir)
      begin
         op(1'b0, 1'b1, 8'h60, 4'hF, d);
         pd_data = d;
      end
      op(1'b0, 1'b1, 8'h5C, 4'hC, {dir, 7'h0, a, 18'h0});
      pd_addr = a;
      pd_flag = dir;
      op(1'b1, 1'b0, 8'h5C, 4'h0, 32'h0);
      // a second start while busy must be dropped whole
      op(1'b0, 1'b1, 8'h5C, 4'hC, {~dir, 7'h0, ~a, 18'h0});
      check({ee_req, ee_write, ee_addr, ee_wdata}, {1'b1, dir, a, pd_data});
      cfg_req = '0;
      n = 0;
      while (up_busy === 1'b1 && n < 40)
      begin
         @(negedge sys_clk);
         n++;
      end
      check(64'(n < 40), 64'h1);
      check(dn_busy, 1'b0);
      pd_flag = ~dir;
      if (dir)
         tbl[a] = pd_data;
      else
         pd_data = tbl[a];
      op(1'b1, 1'b0, 8'h5C, 4'h0, 32'h0);
      op(1'b1, 1'b0, 8'h60, 4'h0, 32'h0);
   endtask

   always @(negedge sys_clk)
   begin
      if (up_ack === 1'b1 || dn_ack === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(64'(up_ack), 64'h0);
         else
            check({dn_rdata, up_rdata}, exp_q.pop_front());
      end
   end

   initial
   begin
      #100000;
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      wrap_up();
   end

   initial
   begin
      logic [7:0] a;
      logic [31:0] d;
      seed = $urandom(32'h0E95AAB1);
      rst_n = 1'b0;
      cfg_req = '0;
      msi_lower_addr = 32'h0;
      msi_64bit_capable = 1'b0;
      dflt_load = 1'b0;
      dflt_value = '0;
      ack_dly = 4'h2;
      {upr, mdat, pd_addr, pd_flag, pd_data} = '0;
      t0 = 32'h04001060;
      t1 = 32'h04000800;
      tsh = '{vga_en: 1'b1, default: '0};
      for (int i = 0; i < 64; i++)
         tbl[i] = 32'hC3005A5A | (32'(i) << 16);
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      check({up_tcfg, dn_tcfg}, {tsh, tsh});
      for (int o = 8'h50; o <= 8'h78; o += 4)
         op(1'b1, 1'b0, 8'(o), 4'h0, 32'h0);
      op(1'b0, 1'b1, 8'h54, 4'hF, $urandom);
      repeat (16)
      begin
         a = wr_offs[$urandom_range(0, 5)];
         d = $urandom;
         op(1'b1, 1'b1, a, (a == 8'h70) ? 4'hF : 4'($urandom), d);
         op(1'b1, 1'b0, a, 4'h0, 32'h0);
      end
      check({up_tcfg, dn_tcfg}, {tsh, tsh});
      cfg_req = '0;
      repeat (4)
      begin
         la = $urandom;
         msi_lower_addr = la;
         msi_64bit_capable = 1'($urandom);
         repeat (2) @(negedge sys_clk);
         check(dn_target, {msi_64bit_capable ? upr : 32'h0, la[31:2], 2'b00});
         check(dn_mdata, mdat);
      end
      dflt_value = cap_slice_pkg::timer_cfg_t'($urandom);
      dflt_load = 1'b1;
      op(1'b0, 1'b1, 8'h70, 4'hF, $urandom);
      dflt_load = 1'b0;
      tsh = dflt_value;
      op(1'b1, 1'b0, 8'h70, 4'h0, 32'h0);
      check({up_tcfg, dn_tcfg}, {tsh, tsh});
      for (int i = 0; i < 4; i++)
      begin
         a = (i == 0) ? 8'h00 : (i == 1) ? 8'h3F : 8'($urandom_range(0, 63));
         vpd(1'b1, a[5:0], $urandom);
         vpd(1'b0, a[5:0], 32'h0);
         vpd(1'b0, 6'($urandom), 32'h0);
      end
      cfg_req = '0;
      repeat (3) @(negedge sys_clk);
      check(64'(exp_q.size()), 64'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
